/* File: hdl/gtc_defs.vh */
// register map, field positions and constants of the gated timer/counter
`ifndef GTC_DEFS_VH
`define GTC_DEFS_VH
`define GTC_ADDR_W 8
`define GTC_OFF_CTRL 8'h00
`define GTC_OFF_CNTL 8'h04
`define GTC_OFF_CNTH 8'h08
`define GTC_OFF_FLAG 8'h0c
`define GTC_OFF_INTEN 8'h10
`define GTC_OFF_CFG 8'h14
`define GTC_OFF_PIN 8'h18
// control register fields
`define GTC_B_ON 0
`define GTC_B_CS 1
`define GTC_B_SYNCN 2
`define GTC_B_OSCEN 3
`define GTC_B_PS_LO 4
`define GTC_B_PS_HI 5
`define GTC_B_GE 6
`define GTC_B_GINV 7
// interrupt enable register fields
`define GTC_B_TIE 0
`define GTC_B_PERIPHERAL_INT_ENABLE 1
`define GTC_B_GIE 2
// configuration register fields
`define GTC_B_GSS 0
`define GTC_B_INTERNAL_OSCILLATOR 1
`define GTC_B_LPMODE 2
`define GTC_B_SLEEP 3
// pin register fields
`define GTC_B_DIR4 0
`define GTC_B_DIR5 1
`define GTC_B_PORT4 2
`define GTC_B_PORT5 3
`define GTC_CTRL_RST 8'h00
`define GTC_CNT_RST 16'h0000
`define GTC_CNT_MAX 16'hffff
`define GTC_PIN_RST 4'h3
`define GTC_ISR_VEC 16'h0004
`define GTC_RESP_OK 2'b00
`define GTC_RESP_ERR 2'b10
`endif

/* File: hdl/gtc_timer.v */
// gated 16-bit timer/counter with AXI4-Lite register slave
//
// Behaviour
// - 16-bit up-counter as high and low byte; byte writes replace count at once
// - source select 0 picks instruction clock, 1 picks external count input
// - internal source advances once per prescaled instruction cycle multiple
// - external source increments on each rising edge after prescaling
// - external mode counts synchronised or asynchronously per sync bypass bit
// - counter mode needs a falling edge before first counted rising edge
// - prescaler divides by 1, 2, 4 or 8 per two-bit select
// - prescaler hidden from software, cleared on any count byte write
// - low-power oscillator enable starts oscillator, which keeps running in sleep
// - oscillator enabled forces pin 5,4 direction to 1 and port bits to 0
// - oscillator usable only with internal oscillator or low-power crystal mode
// - sync bypass counts unsynchronised, keeps counting in sleep, overflow wakes
// - mode switches may drop or add one increment; not prevented
// - byte reads in async mode return valid bytes; software handles overflow between
// - gate source is gate pin or comparator 2, active only with gate enable
// - gate invert bit inverts gate for either source
// - rollover from ffff to 0000 sets overflow flag
// - interrupt needs timer, peripheral and global enables; software clears flag
// - async sleep overflow with enables wakes device; global enable vectors to 0004h
// - special event trigger clears count without flag; byte write wins
// - special event trigger guaranteed only in synchronised counting
`timescale 1ns/1ps
`include "gtc_defs.vh"

module gtc_timer (
	input wire clk_sys,
	input wire rst,
	input wire [`GTC_ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`GTC_ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire instrClkTick,
	input wire externalCountInput,
	input wire gateInputPin,
	input wire comparatorOutput,
	input wire specialEventTrigger,
	output reg lowPowerOscRun,
	output reg overflowIrq,
	output reg wakeRequest,
	output reg [15:0] vectorAddr
);

	// pin inputs: three-stage synchronisers, change accepted when stages 2 and 3 agree
	reg [2:0] extSync_r, gateSync_r, cmpSync_r;
	reg extLevel_r, gateLevel_r, cmpLevel_r;
	reg extPrev_r;
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			extSync_r <= 3'h0;
			gateSync_r <= 3'h0;
			cmpSync_r <= 3'h0;
			extLevel_r <= 1'b0;
			gateLevel_r <= 1'b0;
			cmpLevel_r <= 1'b0;
			extPrev_r <= 1'b0;
		end else begin
			extSync_r <= {extSync_r[1:0], externalCountInput};
			gateSync_r <= {gateSync_r[1:0], gateInputPin};
			cmpSync_r <= {cmpSync_r[1:0], comparatorOutput};
			if (extSync_r[1] == extSync_r[2])
				extLevel_r <= extSync_r[2];
			if (gateSync_r[1] == gateSync_r[2])
				gateLevel_r <= gateSync_r[2];
			if (cmpSync_r[1] == cmpSync_r[2])
				cmpLevel_r <= cmpSync_r[2];
			extPrev_r <= extLevel_r;
		end
	end

	reg [7:0] ctrl_r;
	reg [2:0] intEn_r;
	reg [3:0] cfg_r;
	reg [15:0] count_r;
	reg [2:0] presc_r;
	reg armed_r;
	reg flag_r;

	wire timerOn = ctrl_r[`GTC_B_ON];
	wire extSel = ctrl_r[`GTC_B_CS];
	wire syncBypass = ctrl_r[`GTC_B_SYNCN];
	wire sleeping = cfg_r[`GTC_B_SLEEP];
	wire oscAllowed = cfg_r[`GTC_B_INTERNAL_OSCILLATOR] | cfg_r[`GTC_B_LPMODE];
	wire oscOn = ctrl_r[`GTC_B_OSCEN] & oscAllowed;

	// async mode: the external level is taken at synchroniser stage 2 without the agreement check; the trigger
	// is ignored in this mode, and one edge may be gained/lost when the mode flips
	reg extRaw_r, extRawPrev_r;
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			extRaw_r <= 1'b0;
			extRawPrev_r <= 1'b0;
		end else begin
			extRaw_r <= extSync_r[1];
			extRawPrev_r <= extRaw_r;
		end
	end
	wire extNow = syncBypass ? extRaw_r : extLevel_r;
	wire extWas = syncBypass ? extRawPrev_r : extPrev_r;
	wire extRise = extNow & ~extWas;
	wire extFall = ~extNow & extWas;

	wire gateSrc = cfg_r[`GTC_B_GSS] ? cmpLevel_r : gateLevel_r;
	wire gateOpen = ~ctrl_r[`GTC_B_GE] | (gateSrc ^ ctrl_r[`GTC_B_GINV]);

	// internal source freezes in sleep; async external keeps counting
	wire srcTick = extSel ? (extRise & armed_r) : (instrClkTick & ~sleeping);
	wire extOk = ~extSel | syncBypass | ~sleeping;
	wire inTick = timerOn & gateOpen & srcTick & extOk;

	function [2:0] presMask;
		input [1:0] sel;
		begin
			case (sel)
			2'b00: presMask = 3'h0;
			2'b01: presMask = 3'h1;
			2'b10: presMask = 3'h3;
			default: presMask = 3'h7;
			endcase
		end
	endfunction

	wire [2:0] mask = presMask(ctrl_r[`GTC_B_PS_HI:`GTC_B_PS_LO]);
	wire cntTick = inTick & ((presc_r & mask) == mask);

	// AXI write path
	reg [`GTC_ADDR_W-1:0] awAddr_r;
	reg awHave_r, wHave_r;
	reg [31:0] wData_r;
	reg [3:0] wStrb_r;
	wire wrGo = awHave_r & wHave_r & ~s_axi_bvalid;
	wire wrLo = wrGo & (awAddr_r == `GTC_OFF_CNTL) & wStrb_r[0];
	wire wrHi = wrGo & (awAddr_r == `GTC_OFF_CNTH) & wStrb_r[0];
	wire clrFlag = wrGo & (awAddr_r == `GTC_OFF_FLAG) & wStrb_r[0] & ~wData_r[0];

	function isMapped;
		input [`GTC_ADDR_W-1:0] a;
		begin
			case (a)
			`GTC_OFF_CTRL, `GTC_OFF_CNTL, `GTC_OFF_CNTH, `GTC_OFF_FLAG,
			`GTC_OFF_INTEN, `GTC_OFF_CFG, `GTC_OFF_PIN: isMapped = 1'b1;
			default: isMapped = 1'b0;
			endcase
		end
	endfunction

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			awHave_r <= 1'b0;
			wHave_r <= 1'b0;
			awAddr_r <= {`GTC_ADDR_W{1'b0}};
			wData_r <= 32'h0;
			wStrb_r <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `GTC_RESP_OK;
		end else begin
			s_axi_awready <= ~awHave_r & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready <= ~wHave_r & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid & s_axi_awready) begin
				awHave_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				wHave_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end
			if (wrGo) begin
				awHave_r <= 1'b0;
				wHave_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= isMapped(awAddr_r) ? `GTC_RESP_OK : `GTC_RESP_ERR;
			end else if (s_axi_bvalid & s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// registers, prescaler, count
	reg [15:0] count_nxt;
	always @* begin
		count_nxt = count_r;
		if (cntTick)
			count_nxt = count_r + 16'h0001;
		if (specialEventTrigger & ~(extSel & syncBypass))
			count_nxt = `GTC_CNT_RST;
		if (wrLo)
			count_nxt[7:0] = wData_r[7:0];
		if (wrHi)
			count_nxt[15:8] = wData_r[7:0];
	end

	wire ovf = cntTick & (count_r == `GTC_CNT_MAX);

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctrl_r <= `GTC_CTRL_RST;
			intEn_r <= 3'h0;
			cfg_r <= 4'h0;
			count_r <= `GTC_CNT_RST;
			presc_r <= 3'h0;
			armed_r <= 1'b0;
			flag_r <= 1'b0;
		end else begin
			count_r <= count_nxt;
			if (wrLo | wrHi)
				presc_r <= 3'h0;
			else if (inTick)
				presc_r <= presc_r + 3'h1;
			// arm on falling edge after enabling
			if (~timerOn | ~extSel)
				armed_r <= 1'b0;
			else if (extFall)
				armed_r <= 1'b1;
			// set beats clear
			if (ovf)
				flag_r <= 1'b1;
			else if (clrFlag)
				flag_r <= 1'b0;
			if (wrGo & wStrb_r[0]) begin
				case (awAddr_r)
				`GTC_OFF_CTRL: ctrl_r <= wData_r[7:0];
				`GTC_OFF_INTEN: intEn_r <= wData_r[2:0];
				`GTC_OFF_CFG: cfg_r <= wData_r[3:0];
				default: ;
				endcase
			end
		end
	end

	wire [3:0] pinView = oscOn ? 4'h3 : `GTC_PIN_RST;

	// AXI read path; count bytes are sampled on the system clock so always stable
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `GTC_RESP_OK;
		end else begin
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= isMapped(s_axi_araddr) ? `GTC_RESP_OK : `GTC_RESP_ERR;
				case (s_axi_araddr)
				`GTC_OFF_CTRL: s_axi_rdata <= {24'h0, ctrl_r};
				`GTC_OFF_CNTL: s_axi_rdata <= {24'h0, count_r[7:0]};
				`GTC_OFF_CNTH: s_axi_rdata <= {24'h0, count_r[15:8]};
				`GTC_OFF_FLAG: s_axi_rdata <= {31'h0, flag_r};
				`GTC_OFF_INTEN: s_axi_rdata <= {29'h0, intEn_r};
				`GTC_OFF_CFG: s_axi_rdata <= {28'h0, cfg_r};
				`GTC_OFF_PIN: s_axi_rdata <= {28'h0, pinView};
				default: s_axi_rdata <= 32'h0;
				endcase
			end else if (s_axi_rvalid & s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// outputs
	wire tie = intEn_r[`GTC_B_TIE];
	wire peripheral_int_enable = intEn_r[`GTC_B_PERIPHERAL_INT_ENABLE];
	wire global_int_enable = intEn_r[`GTC_B_GIE];
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lowPowerOscRun <= 1'b0;
			overflowIrq <= 1'b0;
			wakeRequest <= 1'b0;
			vectorAddr <= `GTC_CNT_RST;
		end else begin
			lowPowerOscRun <= oscOn;
			overflowIrq <= flag_r & tie & peripheral_int_enable & global_int_enable;
			wakeRequest <= sleeping & flag_r & timerOn & extSel & syncBypass & tie & peripheral_int_enable;
			vectorAddr <= (flag_r & tie & peripheral_int_enable & global_int_enable) ? `GTC_ISR_VEC : `GTC_CNT_RST;
		end
	end

endmodule // gtc_timer

/* File: dv/gtc_timer_monitor.sv */
// port checker for the gated timer/counter
`timescale 1ns/1ps
`include "gtc_defs.vh"
module gtc_timer_monitor (
	input logic clk_sys,
	input logic rst,
	input logic s_axi_awready,
	input logic s_axi_arready,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic [31:0] s_axi_rdata,
	input logic [1:0] s_axi_rresp,
	input logic overflowIrq,
	input logic [15:0] vectorAddr,
	input logic lowPowerOscRun
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_aw_one_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready longer than one cycle");
	a_ar_one_pulse: assert property (s_axi_arready |=> !s_axi_arready)
		else $error("arready longer than one cycle");
	a_read_answer: assert property (s_axi_arready |=> s_axi_rvalid)
		else $error("no read data after address taken");
	a_r_drops: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data repeated");
	a_b_drops: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	a_err_zero_data: assert property (s_axi_rvalid && s_axi_rresp == `GTC_RESP_ERR
		|-> s_axi_rdata == 32'h0)
		else $error("error read carries data");
	a_vector_on_irq: assert property (overflowIrq |-> vectorAddr == `GTC_ISR_VEC)
		else $error("vector wrong while interrupt");
	a_vector_idle: assert property (!overflowIrq |-> vectorAddr == 16'h0000)
		else $error("vector set without interrupt");
	// only software may drop the request
	a_irq_sw_clear: assert property ($fell(overflowIrq)
		|-> s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
		else $error("interrupt dropped without a write");
	a_osc_by_write: assert property ($rose(lowPowerOscRun)
		|-> s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
		else $error("oscillator started without a write");
endmodule // gtc_timer_monitor
bind gtc_timer gtc_timer_monitor u_gtc_timer_monitor (.clk_sys(clk_sys), .rst(rst),
	.s_axi_awready(s_axi_awready), .s_axi_arready(s_axi_arready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .overflowIrq(overflowIrq),
	.vectorAddr(vectorAddr), .lowPowerOscRun(lowPowerOscRun));

/* File: dv/gtc_ext_model.sv */
// far side: count pin, gate pin and comparator output
`timescale 1ns/1ps
module gtc_ext_model (
	input logic clk_sys,
	output logic extPin,
	output logic gatePin,
	output logic cmpOut
);
	initial extPin = 1'b0;
	initial gatePin = 1'b0;
	initial cmpOut = 1'b0;
	// high held four clocks and low five, longer than the input synchroniser
	task automatic pulses(input int n);
		repeat (n) begin
			@(posedge clk_sys) extPin <= 1'b1;
			repeat (4) @(posedge clk_sys);
			extPin <= 1'b0;
			repeat (4) @(posedge clk_sys);
		end
	endtask
	task automatic gate(input logic pin, input logic cmp);
		@(posedge clk_sys);
		gatePin <= pin;
		cmpOut <= cmp;
		repeat (5) @(posedge clk_sys);
	endtask
endmodule // gtc_ext_model

/* File: dv/gtc_tb.sv */
// self-checking bench for the gated timer/counter
`timescale 1ns/1ps
`include "gtc_defs.vh"
module tb;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, seed = 32'd76, ps, n, r, g;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, tk = 0, trig = 0;
	logic awready, wready, bvalid, arready, rvalid, extPin, gatePin, cmpOut, osc, irq, wake;
	logic [1:0] bresp, rresp;
	logic [15:0] vec;
	logic [33:0] q[$];
	int n_fail = 0, n_compared = 0;
	always #50 clk_sys = ~clk_sys;
	gtc_timer u_gtc_timer (.clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.instrClkTick(tk), .externalCountInput(extPin), .gateInputPin(gatePin),
		.comparatorOutput(cmpOut), .specialEventTrigger(trig), .lowPowerOscRun(osc),
		.overflowIrq(irq), .wakeRequest(wake), .vectorAddr(vec));
	gtc_ext_model u_gtc_ext_model (.clk_sys(clk_sys), .extPin(extPin), .gatePin(gatePin),
		.cmpOut(cmpOut));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic hA, hW, hB;
		hB = 1'b0;
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!hB) begin
			@(negedge clk_sys);
			hA = awready;
			hW = wready;
			hB = bvalid;
			if (hB) chk("bresp", bresp, a > 8'h18 ? `GTC_RESP_ERR : `GTC_RESP_OK);
			@(posedge clk_sys);
			if (hA) awvalid <= 1'b0;
			if (hW) wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic hA, hR;
		hR = 1'b0;
		q.push_back({a > 8'h18 ? `GTC_RESP_ERR : `GTC_RESP_OK, e});
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!hR) begin
			@(negedge clk_sys);
			hA = arready;
			hR = rvalid;
			@(posedge clk_sys);
			if (hA) arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask
	always @(negedge clk_sys) begin
		if (rvalid && rready) chk("read", {rresp, rdata}, q.pop_front());
	end
	task automatic tick(input logic [31:0] k);
		repeat (k) begin
			@(posedge clk_sys) tk <= 1'b1;
			@(posedge clk_sys) tk <= 1'b0;
		end
	endtask
	// unselected gate source always at the opposite level
	task automatic setg(input logic gs, input logic lv);
		u_gtc_ext_model.gate(gs ? !lv : lv, gs ? lv : !lv);
	endtask
	task automatic final_report();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk_sys);
		n_fail++;
		final_report();
	end
	initial begin
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		rd(`GTC_OFF_CTRL, 0);
		rd(`GTC_OFF_PIN, 3);
		rd(8'h1c, 0);
		wr(8'h1c, 1);
		$display("test reset done");
		// odd tick count leaves a prescaler residue the next count byte write must clear
		for (ps = 0; ps < 4; ps++) begin
			n = 8 * (xs() % 4 + 1) + 1;
			r = xs() & 32'hff;
			wr(`GTC_OFF_CNTL, 0);
			wr(`GTC_OFF_CNTH, r);
			wr(`GTC_OFF_CTRL, 1 | ps << 4);
			tick(n);
			wr(`GTC_OFF_CTRL, ps << 4);
			tick(3);
			rd(`GTC_OFF_CNTL, n >> ps);
			rd(`GTC_OFF_CNTH, r);
		end
		$display("test prescale done");
		wr(`GTC_OFF_CNTL, 8'hff);
		wr(`GTC_OFF_CNTH, 8'hff);
		wr(`GTC_OFF_INTEN, 7);
		wr(`GTC_OFF_CTRL, 1);
		tick(1);
		rd(`GTC_OFF_CNTH, 0);
		rd(`GTC_OFF_FLAG, 1);
		chk("irq", irq, 1);
		chk("vector", vec, `GTC_ISR_VEC);
		wr(`GTC_OFF_FLAG, 0);
		repeat (2) @(negedge clk_sys);
		chk("irq", irq, 0);
		wr(`GTC_OFF_CNTL, 8'h12);
		@(posedge clk_sys) trig <= 1'b1;
		@(posedge clk_sys) trig <= 1'b0;
		rd(`GTC_OFF_CNTL, 0);
		rd(`GTC_OFF_FLAG, 0);
		wr(`GTC_OFF_CTRL, 0);
		$display("test overflow done");
		// gate shut for the first ticks, open for the last five
		for (g = 0; g < 4; g++) begin
			wr(`GTC_OFF_CNTL, 0);
			wr(`GTC_OFF_CFG, g >> 1);
			wr(`GTC_OFF_CTRL, 8'h41 | g << 7);
			setg(g[1], g[0]);
			tick(4);
			setg(g[1], !g[0]);
			tick(5);
			wr(`GTC_OFF_CTRL, 0);
			rd(`GTC_OFF_CNTL, 5);
		end
		$display("test gate done");
		for (g = 0; g < 2; g++) begin
			wr(`GTC_OFF_CNTL, 0);
			wr(`GTC_OFF_CTRL, 3 | g << 2);
			u_gtc_ext_model.pulses(4);
			wr(`GTC_OFF_CTRL, 0);
			rd(`GTC_OFF_CNTL, 3);
		end
		$display("test external done");
		wr(`GTC_OFF_CFG, 2);
		wr(`GTC_OFF_CTRL, 8);
		repeat (2) @(negedge clk_sys);
		chk("osc", osc, 1);
		rd(`GTC_OFF_PIN, 3);
		wr(`GTC_OFF_CFG, 0);
		repeat (2) @(negedge clk_sys);
		chk("osc", osc, 0);
		wr(`GTC_OFF_CFG, 4);
		repeat (2) @(negedge clk_sys);
		chk("osc", osc, 1);
		$display("test oscillator done");
		wr(`GTC_OFF_INTEN, 3);
		wr(`GTC_OFF_CNTL, 8'hff);
		wr(`GTC_OFF_CNTH, 8'hff);
		wr(`GTC_OFF_CFG, 8'h0a);
		wr(`GTC_OFF_CTRL, 7);
		u_gtc_ext_model.pulses(2);
		chk("wake", wake, 1);
		chk("irq", irq, 0);
		chk("vector", vec, 0);
		$display("test sleep done");
		final_report();
	end
endmodule // tb
